// [hdl/ftc_params.svh]
// Offsets, field positions, reset values and timing counts of the flash timing block
`ifndef FTC_PARAMS_SVH
`define FTC_PARAMS_SVH

// Register offsets
`define FTC_OFS_CFG        3'h0
`define FTC_OFS_TRIM       3'h1
`define FTC_OFS_CMD        3'h2
`define FTC_OFS_STATUS     3'h3
`define FTC_OFS_DATA_HIGH  3'h4
`define FTC_OFS_DATA_LOW   3'h5
`define FTC_OFS_WDATA_HIGH 3'h6
`define FTC_OFS_WDATA_LOW  3'h7

// Field positions inside the configuration, trim and status registers
`define FTC_RCC_LSB        0
`define FTC_RCC_MSB        1
`define FTC_DIV_LSB        4
`define FTC_DIV_MSB        7
`define FTC_TRIM_BIT       0
`define FTC_STAT_BUSY      0
`define FTC_STAT_RDVALID   1

// Reset values: slowest read stretch and smallest documented divisor
`define FTC_CFG_RESET      8'h43
`define FTC_TRIM_RESET     8'h00

// Divisor table
`define FTC_DIV_CODE_FIRST 4'h4
`define FTC_DIV_LOW        9'h008
`define FTC_DIV_MAX        384

// Timing: one timing-clock period taken as 1 us when properly configured
`define FTC_TICK_US        1
`define FTC_WRITE_US       42
`define FTC_ERASE_US       20000
`define FTC_WRITE_TICKS    (`FTC_WRITE_US / `FTC_TICK_US)
`define FTC_ERASE_TICKS    (`FTC_ERASE_US / `FTC_TICK_US)

`endif

// [hdl/ftc_pkg.sv]
// Types of the flash timing block
package ftc_pkg;

  typedef enum logic [1:0] {
    FTC_IDLE = 2'b00,
    FTC_READ = 2'b01,
    FTC_PROG = 2'b10
  } ftc_state_t;

  typedef enum logic [1:0] {
    FTC_OP_NONE  = 2'b00,
    FTC_OP_WRITE = 2'b01,
    FTC_OP_BLOCK = 2'b10,
    FTC_OP_BULK  = 2'b11
  } ftc_op_t;

endpackage : ftc_pkg

// [hdl/ftc_tick_if.sv]
// Link between the sequencer and the timing-clock divider
`timescale 1ns/10ps
`default_nettype none

interface ftc_tick_if;
  logic [3:0] div_code;
  logic       run;
  logic       tick;

  modport seq (output div_code, output run, input tick);
  modport div (input div_code, input run, output tick);
endinterface : ftc_tick_if

`default_nettype wire

// [hdl/ftc_divider.sv]
// Programmable divider that makes the flash timing clock from the core clock
`timescale 1ns/10ps
`default_nettype none
`include "ftc_params.svh"

module ftc_divider #(
  parameter int CNT_W = 9
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  ftc_tick_if.div   tif
);
  import ftc_pkg::*;

  initial begin
    if ((1 << CNT_W) <= `FTC_DIV_MAX) $error("ftc_divider: CNT_W too small");
  end

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] divisor;
  logic             wrap;

  // Codes below the first documented one clamp to the smallest divisor
  always_comb begin
    case (tif.div_code)
      4'h4:    divisor = CNT_W'(9'h008);
      4'h5:    divisor = CNT_W'(9'h00C);
      4'h6:    divisor = CNT_W'(9'h010);
      4'h7:    divisor = CNT_W'(9'h018);
      4'h8:    divisor = CNT_W'(9'h020);
      4'h9:    divisor = CNT_W'(9'h030);
      4'hA:    divisor = CNT_W'(9'h040);
      4'hB:    divisor = CNT_W'(9'h060);
      4'hC:    divisor = CNT_W'(9'h080);
      4'hD:    divisor = CNT_W'(9'h0C0);
      4'hE:    divisor = CNT_W'(9'h100);
      4'hF:    divisor = CNT_W'(9'h180);
      default: divisor = CNT_W'(`FTC_DIV_LOW);
    endcase
  end

  assign wrap     = (cnt == divisor - CNT_W'(1));
  assign tif.tick = tif.run && wrap;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (!tif.run || wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  // Cycles since the last tick, for the check below
  logic [CNT_W-1:0] a_gap;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_gap <= '0;
    end else if (!tif.run || tif.tick) begin
      a_gap <= '0;
    end else begin
      a_gap <= a_gap + CNT_W'(1);
    end
  end

  div_period_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tif.tick && $stable(tif.div_code) |-> a_gap == divisor - CNT_W'(1))
    else $error("timing tick period differs from divisor");

endmodule : ftc_divider

`default_nettype wire

// [hdl/ftc_flash_timing.sv]
// Flash timing block: read-cycle stretch, timing divider and program/erase sequencer
//
// Behaviour
// - Each flash read lasts 1 to 4 core cycles as set by the read-cycle field plus one.
// - The write and erase timing clock is the core clock through a programmable divider.
// - Divisor codes 0100 to 1101 give 8 to 192, and 1110 and 1111 give reserved 256 and 384.
// - A word write lasts 42 timing periods and an erase 20000, with the trim bit at 0.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ftc_params.svh"

module ftc_flash_timing #(
  parameter int ADDR_W      = 16,
  parameter int ERASE_TICKS = `FTC_ERASE_TICKS,
  parameter int WRITE_TICKS = `FTC_WRITE_TICKS
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  // Register port
  input  wire logic [2:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // Core fetch port and program/erase address
  input  wire logic              fetch_req_i,
  input  wire logic [ADDR_W-1:0] fetch_addr_i,
  output logic                   fetch_ready_o,
  output logic                   fetch_done_o,
  output logic      [15:0]       fetch_data_o,
  input  wire logic [ADDR_W-1:0] prog_addr_i,
  // Flash array side
  output logic      [ADDR_W-1:0] flash_addr_o,
  output logic                   flash_rd_o,
  input  wire logic [15:0]       flash_rdata_i,
  output logic      [15:0]       flash_wdata_o,
  output logic                   flash_write_o,
  output logic                   flash_block_erase_o,
  output logic                   flash_bulk_erase_o,
  output logic                   flash_tick_o,
  output logic                   erase_time_trim_bit_o,
  output logic                   busy_o
);
  import ftc_pkg::*;

  initial begin
    if (ERASE_TICKS < 1 || ERASE_TICKS > 65535) $error("ERASE_TICKS out of range");
    if (WRITE_TICKS < 1 || WRITE_TICKS > 65535) $error("WRITE_TICKS out of range");
    if (ADDR_W < 1) $error("ADDR_W must be positive");
  end

  // Reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  logic [7:0]        flash_config_register;
  logic [7:0]        trim_register_zero;
  logic [15:0]       read_data;
  logic [15:0]       write_data;
  logic              rd_valid;
  ftc_state_t        state;
  ftc_state_t        next_state;
  ftc_op_t           op;
  logic [1:0]        rd_cnt;
  logic [15:0]       tick_cnt;
  logic [15:0]       tick_target;
  logic [ADDR_W-1:0] addr_q;

  ftc_tick_if tif ();

  ftc_divider #(.CNT_W(9)) u_div (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .tif     (tif)
  );

  // Register decode
  wire [1:0] read_cycle_count_field     = flash_config_register[`FTC_RCC_MSB:`FTC_RCC_LSB];
  wire [3:0] flash_timing_divisor_field = flash_config_register[`FTC_DIV_MSB:`FTC_DIV_LSB];
  wire       wr_cfg    = reg_wr_i && (reg_addr_i == `FTC_OFS_CFG);
  wire       wr_trim   = reg_wr_i && (reg_addr_i == `FTC_OFS_TRIM);
  wire       wr_cmd    = reg_wr_i && (reg_addr_i == `FTC_OFS_CMD);
  wire       wr_wdh    = reg_wr_i && (reg_addr_i == `FTC_OFS_WDATA_HIGH);
  wire       wr_wdl    = reg_wr_i && (reg_addr_i == `FTC_OFS_WDATA_LOW);
  wire       rd_data_h = reg_rd_i && (reg_addr_i == `FTC_OFS_DATA_HIGH);
  wire [1:0] cmd_op    = reg_wdata_i[1:0];
  wire       idle      = (state == FTC_IDLE);
  wire       fetch_go  = idle && fetch_req_i;
  wire       prog_go   = idle && !fetch_req_i && wr_cmd && (cmd_op != 2'b00);
  wire       rd_last   = (state == FTC_READ) && (rd_cnt == read_cycle_count_field);
  wire       prog_last = (state == FTC_PROG) && tif.tick && (tick_cnt == tick_target - 16'h0001);
  wire [7:0] status    = {6'h00, rd_valid, !idle};

  assign tif.div_code  = flash_timing_divisor_field;
  assign tif.run       = (state == FTC_PROG);
  assign fetch_ready_o = idle;
  assign busy_o        = !idle;
  assign flash_tick_o  = tif.tick;
  assign flash_rd_o    = (state == FTC_READ);
  assign flash_addr_o  = addr_q;
  assign flash_wdata_o = write_data;
  assign erase_time_trim_bit_o = trim_register_zero[`FTC_TRIM_BIT];
  assign flash_write_o       = (state == FTC_PROG) && (op == FTC_OP_WRITE);
  assign flash_block_erase_o = (state == FTC_PROG) && (op == FTC_OP_BLOCK);
  assign flash_bulk_erase_o  = (state == FTC_PROG) && (op == FTC_OP_BULK);

  // State sequencing; fetch wins over a command in the same cycle
  always_comb begin
    case (state)
      FTC_IDLE: next_state = fetch_go ? FTC_READ : (prog_go ? FTC_PROG : FTC_IDLE);
      FTC_READ: next_state = rd_last ? FTC_IDLE : FTC_READ;
      FTC_PROG: next_state = prog_last ? FTC_IDLE : FTC_PROG;
      default:  next_state = FTC_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= FTC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Software registers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      flash_config_register <= `FTC_CFG_RESET;
      trim_register_zero    <= `FTC_TRIM_RESET;
      write_data            <= 16'h0000;
    end else begin
      if (wr_cfg) flash_config_register <= reg_wdata_i;
      if (wr_trim) trim_register_zero <= {7'h00, reg_wdata_i[`FTC_TRIM_BIT]};
      if (wr_wdh) write_data[15:8] <= reg_wdata_i;
      if (wr_wdl) write_data[7:0] <= reg_wdata_i;
    end
  end

  // Read stretch counter and capture of the array word
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_cnt       <= 2'b00;
      read_data    <= 16'h0000;
      fetch_done_o <= 1'b0;
      fetch_data_o <= 16'h0000;
    end else begin
      fetch_done_o <= rd_last;
      if (state != FTC_READ || rd_last) begin
        rd_cnt <= 2'b00;
      end else begin
        rd_cnt <= rd_cnt + 2'b01;
      end
      if (rd_last) begin
        read_data    <= flash_rdata_i;
        fetch_data_o <= flash_rdata_i;
      end
    end
  end

  // Read-valid flag: set wins over the clear made by reading the high byte
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
    end else if (rd_last) begin
      rd_valid <= 1'b1;
    end else if (rd_data_h) begin
      rd_valid <= 1'b0;
    end
  end

  // Address and operation latch, and timing-period count
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_q      <= '0;
      op          <= FTC_OP_NONE;
      tick_cnt    <= 16'h0000;
      tick_target <= 16'h0001;
    end else begin
      if (fetch_go) addr_q <= fetch_addr_i;
      if (prog_go) begin
        addr_q      <= prog_addr_i;
        op          <= ftc_op_t'(cmd_op);
        tick_target <= (cmd_op == 2'b01) ? 16'(WRITE_TICKS) : 16'(ERASE_TICKS);
      end
      if (state != FTC_PROG) begin
        tick_cnt <= 16'h0000;
      end else if (tif.tick) begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `FTC_OFS_CFG:        reg_rdata_o <= flash_config_register;
        `FTC_OFS_TRIM:       reg_rdata_o <= trim_register_zero;
        `FTC_OFS_STATUS:     reg_rdata_o <= status;
        `FTC_OFS_DATA_HIGH:  reg_rdata_o <= read_data[15:8];
        `FTC_OFS_DATA_LOW:   reg_rdata_o <= read_data[7:0];
        `FTC_OFS_WDATA_HIGH: reg_rdata_o <= write_data[15:8];
        `FTC_OFS_WDATA_LOW:  reg_rdata_o <= write_data[7:0];
        default:             reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Checking helpers
  logic [2:0]  a_rd_len;
  logic [15:0] a_ticks;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      a_rd_len <= 3'h0;
      a_ticks  <= 16'h0000;
    end else begin
      a_rd_len <= flash_rd_o ? a_rd_len + 3'h1 : 3'h0;
      a_ticks  <= (state != FTC_PROG) ? 16'h0000 : a_ticks + {15'h0000, tif.tick};
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  read_stretch_a: assert property (
    fetch_done_o && $stable(read_cycle_count_field)
    |-> a_rd_len == {1'b0, read_cycle_count_field} + 3'h1)
    else $error("read stretch length differs from field");

  read_start_a: assert property (
    fetch_go |=> flash_rd_o && flash_addr_o == $past(fetch_addr_i))
    else $error("accepted fetch did not start a read");

  prog_length_a: assert property (
    (state == FTC_PROG) && (next_state == FTC_IDLE) |-> a_ticks + 16'h0001 == tick_target)
    else $error("program or erase left before its timing count");

  tick_only_prog_a: assert property (
    tif.tick |-> state == FTC_PROG)
    else $error("timing tick outside program or erase");

  write_len_a: assert property (
    prog_go && cmd_op == 2'b01 |=> tick_target == 16'(WRITE_TICKS) && flash_write_o)
    else $error("word write not loaded with its period count");

  // Only one operation level may drive the array at a time
  op_onehot_a: assert property (
    (state == FTC_PROG) |-> $onehot({flash_write_o, flash_block_erase_o, flash_bulk_erase_o}))
    else $error("program or erase levels not exactly one");

  prog_start_a: assert property (
    prog_go |=> busy_o && flash_addr_o == $past(prog_addr_i))
    else $error("accepted command did not start at its address");

  read_capture_a: assert property (
    rd_last |=> rd_valid && fetch_data_o == $past(flash_rdata_i))
    else $error("finished read did not capture the array word");

  read_busy_a: assert property (
    flash_rd_o |-> !fetch_ready_o && busy_o && !tif.tick)
    else $error("read cycle not shown as busy");

  rd_end_a: assert property (
    rd_last |-> a_rd_len == {1'b0, read_cycle_count_field})
    else $error("read ended off its stretch count");

  data_high_a: assert property (
    rd_data_h && !rd_last |=> reg_rdata_o == $past(read_data[15:8]) && !rd_valid)
    else $error("high data read wrong or flag not cleared");

  cover_read_c:  cover property (fetch_done_o && read_cycle_count_field == 2'b11);
  cover_write_c: cover property (flash_write_o && prog_last);
  cover_erase_c: cover property (flash_block_erase_o && prog_last);
  cover_bulk_c:  cover property (flash_bulk_erase_o && prog_last);
  cover_race_c:  cover property (fetch_go && wr_cmd);

endmodule : ftc_flash_timing

`default_nettype wire

// [tb/ftc_flash_model.sv]
// Behavioural flash array answering reads with an address-derived word
`timescale 1ns/10ps
`default_nettype none

module ftc_flash_model (
  input  wire logic        mclk_i,
  input  wire logic [15:0] flash_addr_i,
  input  wire logic        flash_rd_i,
  output logic      [15:0] flash_rdata_o
);
  logic [15:0] last_word = 16'h0000;

  always_ff @(posedge mclk_i) begin
    last_word <= flash_rdata_o;
  end

  // Outside a read the bus shows the inverse of its previous-cycle value, so a stale copy returns every other cycle
  assign flash_rdata_o = flash_rd_i ? ({flash_addr_i[7:0], flash_addr_i[15:8]} ^ 16'h5A3C)
                                    : ~last_word;
endmodule : ftc_flash_model

`default_nettype wire

// [tb/flash_timing_config_bench.sv]
// Self-checking bench of the flash timing block
`timescale 1ns/10ps
`default_nettype none
`include "ftc_params.svh"

module flash_timing_config_bench;
  logic        mclk_i       = 1'b0;
  logic        rstn_i       = 1'b0;
  logic [2:0]  reg_addr_i   = 3'h0;
  logic [7:0]  reg_wdata_i  = 8'h00;
  logic        reg_wr_i     = 1'b0;
  logic        reg_rd_i     = 1'b0;
  logic        fetch_req_i  = 1'b0;
  logic [15:0] fetch_addr_i = 16'h0000;
  logic [15:0] prog_addr_i  = 16'h0040;
  logic [7:0]  reg_rdata_o;
  logic        fetch_ready_o;
  logic        fetch_done_o;
  logic [15:0] fetch_data_o;
  logic [15:0] flash_addr_o;
  logic        flash_rd_o;
  logic [15:0] flash_rdata_i;
  logic [15:0] flash_wdata_o;
  logic        flash_write_o;
  logic        flash_block_erase_o;
  logic        flash_bulk_erase_o;
  logic        flash_tick_o;
  logic        erase_time_trim_bit_o;
  logic        busy_o;
  int          num_errors   = 0;
  int          tests_run    = 0;

  always #10 mclk_i = ~mclk_i;

  ftc_flash_timing #(.ERASE_TICKS(5), .WRITE_TICKS(3)) u_dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .fetch_req_i(fetch_req_i), .fetch_addr_i(fetch_addr_i), .fetch_ready_o(fetch_ready_o),
    .fetch_done_o(fetch_done_o), .fetch_data_o(fetch_data_o), .prog_addr_i(prog_addr_i),
    .flash_addr_o(flash_addr_o), .flash_rd_o(flash_rd_o), .flash_rdata_i(flash_rdata_i),
    .flash_wdata_o(flash_wdata_o), .flash_write_o(flash_write_o),
    .flash_block_erase_o(flash_block_erase_o), .flash_bulk_erase_o(flash_bulk_erase_o),
    .flash_tick_o(flash_tick_o), .erase_time_trim_bit_o(erase_time_trim_bit_o),
    .busy_o(busy_o)
  );

  ftc_flash_model u_flash (
    .mclk_i(mclk_i), .flash_addr_i(flash_addr_o), .flash_rd_i(flash_rd_o),
    .flash_rdata_o(flash_rdata_i)
  );

  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : reg_rd

  function automatic int div_of(input logic [3:0] c);
    case (c)
      4'h5: return 12;
      4'h6: return 16;
      4'h7: return 24;
      4'h8: return 32;
      4'h9: return 48;
      4'hA: return 64;
      4'hB: return 96;
      4'hC: return 128;
      4'hD: return 192;
      4'hE: return 256;
      4'hF: return 384;
      default: return 8;
    endcase
  endfunction : div_of

  task automatic reset_case();
    logic [7:0] d;
    reg_rd(`FTC_OFS_CFG, d);
    chk("cfg_reset", 16'h0043, {8'h00, d});
    @(posedge mclk_i);
    #1;
    chk("rdata_idle", 16'h0000, {8'h00, reg_rdata_o});
    reg_rd(`FTC_OFS_TRIM, d);
    chk("trim_reset", 16'h0000, {8'h00, d});
    reg_wr(`FTC_OFS_STATUS, 8'hFF);
    reg_rd(`FTC_OFS_STATUS, d);
    chk("status_ro", 16'h0000, {8'h00, d});
    reg_wr(`FTC_OFS_TRIM, 8'h01);
    reg_wr(`FTC_OFS_WDATA_HIGH, 8'hC3);
    reg_wr(`FTC_OFS_WDATA_LOW, 8'h5A);
    #1;
    chk("trim_out", 16'h0001, {15'h0000, erase_time_trim_bit_o});
    chk("wdata_out", 16'hC35A, flash_wdata_o);
    reg_wr(`FTC_OFS_CMD, 8'h00);
    @(posedge mclk_i);
    #1;
    chk("cmd_none_busy", 16'h0000, {15'h0000, busy_o});
  endtask : reset_case

  task automatic fetch_case(input logic [1:0] fld, input logic [15:0] a);
    int         cyc;
    int         rd_cnt;
    logic [7:0] d;
    logic [15:0] w;
    cyc    = 0;
    rd_cnt = 0;
    w      = {a[7:0], a[15:8]} ^ 16'h5A3C;
    reg_wr(`FTC_OFS_CFG, {4'h4, 2'b00, fld});
    @(posedge mclk_i);
    fetch_req_i  <= 1'b1;
    fetch_addr_i <= a;
    @(posedge mclk_i);
    fetch_req_i  <= 1'b0;
    #1;
    cyc = 1;
    if (flash_rd_o === 1'b1) rd_cnt++;
    while (fetch_done_o !== 1'b1 && cyc < 8) begin
      @(posedge mclk_i);
      #1;
      cyc++;
      if (flash_rd_o === 1'b1) rd_cnt++;
    end
    if (fetch_done_o !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
    chk("read_cycles", {14'h0000, fld} + 16'h0001, 16'(rd_cnt));
    chk("done_cycle", {14'h0000, fld} + 16'h0002, 16'(cyc));
    chk("fetch_data", w, fetch_data_o);
    chk("flash_addr", a, flash_addr_o);
    repeat (2) @(posedge mclk_i);
    reg_rd(`FTC_OFS_STATUS, d);
    chk("status_valid", 16'h0002, {8'h00, d});
    reg_rd(`FTC_OFS_DATA_HIGH, d);
    chk("data_high", {8'h00, w[15:8]}, {8'h00, d});
    reg_rd(`FTC_OFS_DATA_LOW, d);
    chk("data_low", {8'h00, w[7:0]}, {8'h00, d});
    reg_rd(`FTC_OFS_STATUS, d);
    chk("status_clear", 16'h0000, {8'h00, d});
  endtask : fetch_case

  task automatic op_case(input logic [1:0] code, input logic [3:0] dv, input int t);
    int         d;
    int         cyc;
    int         ticks;
    int         bad;
    logic [2:0] lvl;
    d     = div_of(dv);
    cyc   = 0;
    ticks = 0;
    bad   = 0;
    lvl   = {code == 2'b01, code == 2'b10, code == 2'b11};
    reg_wr(`FTC_OFS_CFG, {dv, 4'h3});
    reg_wr(`FTC_OFS_CMD, {6'h00, code});
    #1;
    while (busy_o === 1'b1 && cyc < 30000) begin
      cyc++;
      if ({flash_write_o, flash_block_erase_o, flash_bulk_erase_o} !== lvl) bad++;
      if (fetch_ready_o !== 1'b0) bad++;
      if (flash_addr_o !== prog_addr_i) bad++;
      if (flash_tick_o === 1'b1) begin
        ticks++;
        chk("tick_phase", 16'h0000, 16'(cyc % d));
      end
      @(posedge mclk_i);
      #1;
    end
    if (cyc >= 30000) begin
      num_errors++;
      report_and_stop();
    end
    chk("op_levels", 16'h0000, 16'(bad));
    chk("tick_count", 16'(t), 16'(ticks));
    chk("op_length", 16'(t * d), 16'(cyc));
  endtask : op_case

  // Fetch and command in one cycle, then a command while busy: both commands ignored
  task automatic race_case();
    reg_wr(`FTC_OFS_CFG, 8'hA1);
    @(posedge mclk_i);
    fetch_req_i  <= 1'b1;
    fetch_addr_i <= 16'h0123;
    reg_wr_i     <= 1'b1;
    reg_addr_i   <= `FTC_OFS_CMD;
    reg_wdata_i  <= 8'h01;
    @(posedge mclk_i);
    fetch_req_i <= 1'b0;
    reg_wr_i    <= 1'b0;
    #1;
    chk("race_rd", 16'h0001, {15'h0000, flash_rd_o});
    chk("race_wr", 16'h0000, {15'h0000, flash_write_o});
    reg_wr(`FTC_OFS_CMD, 8'h02);
    repeat (3) @(posedge mclk_i);
    #1;
    chk("busy_cmd_ignored", 16'h0000, {15'h0000, busy_o});
  endtask : race_case

  initial begin
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_case();
    for (int f = 0; f < 4; f++) begin
      fetch_case(2'(f), 16'hA1B2 + 16'(f * 16'h0313));
    end
    race_case();
    op_case(2'b01, 4'h0, 3);
    for (int c = 4; c < 16; c++) begin
      op_case(2'b01, 4'(c), 3);
    end
    op_case(2'b10, 4'hA, 5);
    op_case(2'b11, 4'hA, 5);
    report_and_stop();
  end
endmodule : flash_timing_config_bench

`default_nettype wire
